// ===== hw/pump_pkg.sv
package pump_pkg;
   // register byte addresses on the bus
   localparam logic [7:0]  ADDR_FUNC       = 8'h00;
   localparam logic [7:0]  ADDR_LOGIC      = 8'h04;
   localparam logic [7:0]  ADDR_RATE_SEL   = 8'h08;
   localparam logic [7:0]  ADDR_FILL       = 8'h0c;
   localparam logic [7:0]  ADDR_EMPTY      = 8'h10;
   localparam logic [7:0]  ADDR_STATUS     = 8'h14;
   // reset values
   localparam logic [23:0] FUNC_RST        = 24'h000000;
   localparam logic [7:0]  LOGIC_RST       = 8'h00;
   localparam logic [1:0]  RATE_SEL_RST    = 2'h0;
   localparam logic [15:0] LIMIT_RST       = 16'h0000;
   // field positions
   localparam int          FUNC_W          = 8;
   localparam int          RSEL_EN_BIT     = 0;
   localparam int          RSEL_FILL_BIT   = 1;
   localparam int          STAT_LEAD_LSB   = 4;
   localparam int          STAT_STAGE_LSB  = 8;
   // relay control function codes and relay logic value
   localparam logic [7:0]  FUNC_FIX_ASSIST = 8'h32;
   localparam logic [7:0]  FUNC_FIX_BACKUP = 8'h33;
   localparam logic [7:0]  FUNC_ALT_ASSIST = 8'h34;
   localparam logic [7:0]  LOGIC_RELAY     = 8'h02;
   // group size
   localparam int          NUM_RELAYS      = 3;
   // rate settle time between rate-driven starts
   localparam longint      CLK_HZ          = 50000000;
   localparam longint      RATE_SETTLE_MS  = 1000;
   localparam int          RATE_SETTLE_CYC = int'(CLK_HZ * RATE_SETTLE_MS / 1000);

   typedef enum logic [3:0] {
      MODE_NONE       = 4'b0001,
      MODE_FIX_ASSIST = 4'b0010,
      MODE_FIX_BACKUP = 4'b0100,
      MODE_ALT_ASSIST = 4'b1000
   } mode_type;
endpackage

// ===== hw/pump_regs_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pump_regs_if;
   logic [23:0] func;
   logic [7:0]  logic_set;
   logic [1:0]  rate_pumping_select;
   logic [15:0] filling_rate_limit;
   logic [15:0] emptying_rate_limit;
   logic [31:0] status;

   modport regs (output func, output logic_set, output rate_pumping_select,
                 output filling_rate_limit, output emptying_rate_limit, input status);
   modport core (input func, input logic_set, input rate_pumping_select,
                 input filling_rate_limit, input emptying_rate_limit, output status);
endinterface
`default_nettype wire

// ===== hw/pump_ahb_regs.sv
`timescale 1ns/10ps
`default_nettype none
module pump_ahb_regs
   import pump_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   pump_regs_if.regs        rif
);
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic        take;

   // zero wait states, so an address phase is taken whenever the bus is ready
   assign take = hsel && hready && htrans[1];

   // write address held for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= take && hwrite;
         wr_addr_q <= haddr;
      end
   end

   // register writes; unmapped addresses are ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rif.func                <= FUNC_RST;
         rif.logic_set           <= LOGIC_RST;
         rif.rate_pumping_select <= RATE_SEL_RST;
         rif.filling_rate_limit  <= LIMIT_RST;
         rif.emptying_rate_limit <= LIMIT_RST;
      end else if (wr_pend_q) begin
         if (wr_addr_q == ADDR_FUNC) begin
            rif.func <= hwdata[23:0];
         end else if (wr_addr_q == ADDR_LOGIC) begin
            rif.logic_set <= hwdata[7:0];
         end else if (wr_addr_q == ADDR_RATE_SEL) begin
            rif.rate_pumping_select <= hwdata[1:0];
         end else if (wr_addr_q == ADDR_FILL) begin
            rif.filling_rate_limit <= hwdata[15:0];
         end else if (wr_addr_q == ADDR_EMPTY) begin
            rif.emptying_rate_limit <= hwdata[15:0];
         end
      end
   end

   // read data is fetched in the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (take && !hwrite) begin
         if (haddr == ADDR_FUNC) begin
            hrdata <= {8'h00, rif.func};
         end else if (haddr == ADDR_LOGIC) begin
            hrdata <= {24'h000000, rif.logic_set};
         end else if (haddr == ADDR_RATE_SEL) begin
            hrdata <= {30'h0, rif.rate_pumping_select};
         end else if (haddr == ADDR_FILL) begin
            hrdata <= {16'h0000, rif.filling_rate_limit};
         end else if (haddr == ADDR_EMPTY) begin
            hrdata <= {16'h0000, rif.emptying_rate_limit};
         end else if (haddr == ADDR_STATUS) begin
            hrdata <= rif.status;
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end
endmodule
`default_nettype wire

// ===== hw/relay_mapper.sv
`timescale 1ns/10ps
`default_nettype none
module relay_mapper
   import pump_pkg::*;
(
   input  wire mode_type    mode,
   input  wire logic [1:0]  stage,
   input  wire logic [1:0]  lead,
   input  wire logic [2:0]  member,
   output logic      [2:0]  relays
);
   logic [2:0] pos;

   // relay that takes the given place in the start order of this cycle
   function automatic logic [1:0] rot(input logic [1:0] base, input int step);
      logic [2:0] s;
      s = 3'(base) + 3'(step);
      rot = (s >= 3'(NUM_RELAYS)) ? 2'(s - 3'(NUM_RELAYS)) : s[1:0];
   endfunction

   always_comb begin
      relays = 3'h0;
      pos    = 3'h0;
      case (mode)
         MODE_FIX_ASSIST: begin
            for (int i = 0; i < NUM_RELAYS; i++) relays[i] = (stage > 2'(i));
         end
         MODE_FIX_BACKUP: begin
            for (int i = 0; i < NUM_RELAYS; i++) relays[i] = (stage == 2'(i + 1));
         end
         MODE_ALT_ASSIST: begin
            // rotated start order, all started pumps stay on together
            for (int j = 0; j < NUM_RELAYS; j++) begin
               pos = 3'(rot(lead, j));
               if (stage > 2'(j)) relays[pos[1:0]] = 1'b1;
            end
         end
         default: relays = 3'h0;
      endcase
      relays = relays & member;
   end
endmodule
`default_nettype wire

// ===== hw/pump_relay_sequencer.sv
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pump_relay_sequencer
   import pump_pkg::*;
#(
   parameter int RATE_SETTLE = RATE_SETTLE_CYC
)(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output var  logic [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic [2:0]          on_level,
   input  wire logic                off_level,
   input  wire logic signed [15:0]  level_rate,
   output var  logic [2:0]          relay_q
);
   pump_regs_if rif ();

   logic [2:0]  on_meta_q;
   logic [2:0]  on_sync_q;
   logic [2:0]  on_prev_q;
   logic        off_meta_q;
   logic        off_sync_q;
   logic        off_prev_q;
   logic [2:0]  on_rise;
   logic        off_rise;
   logic [1:0]  stage_q;
   logic [1:0]  stage_d;
   logic [1:0]  lead_q;
   logic [31:0] settle_cnt_q;
   logic        settle_done;
   logic        rate_short;
   logic        rate_en;
   logic signed [16:0] rate_eff;
   logic [2:0]  member;
   logic [2:0]  relay_d;
   logic        relay_logic_ok;
   mode_type    mode;

   // next lead relay, wrapping from the last relay back to the first
   function automatic logic [1:0] next_lead(input logic [1:0] cur);
      next_lead = (cur == 2'(NUM_RELAYS - 1)) ? 2'h0 : 2'(cur + 2'h1);
   endfunction

   // duty and start method are both implied by the group's function code
   function automatic mode_type decode_mode(input logic [7:0] f);
      if (f == FUNC_FIX_ASSIST) begin
         decode_mode = MODE_FIX_ASSIST;
      end else if (f == FUNC_FIX_BACKUP) begin
         decode_mode = MODE_FIX_BACKUP;
      end else if (f == FUNC_ALT_ASSIST) begin
         decode_mode = MODE_ALT_ASSIST;
      end else begin
         decode_mode = MODE_NONE;
      end
   endfunction

   // register slave; never stalls and never errors
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   pump_ahb_regs pump_ahb_regs_inst (
      .hclk    (hclk),
      .hresetn (hresetn),
      .hsel    (hsel),
      .haddr   (haddr[7:0]),
      .htrans  (htrans),
      .hwrite  (hwrite),
      .hwdata  (hwdata),
      .hready  (hready),
      .hrdata  (hrdata),
      .rif     (rif.regs)
   );

   // level comparators are asynchronous to hclk, two flops before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         on_meta_q  <= 3'h0;
         on_sync_q  <= 3'h0;
         off_meta_q <= 1'b0;
         off_sync_q <= 1'b0;
      end else begin
         on_meta_q  <= on_level;
         on_sync_q  <= on_meta_q;
         off_meta_q <= off_level;
         off_sync_q <= off_meta_q;
      end
   end

   // edge history taken from the second flop only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         on_prev_q  <= 3'h0;
         off_prev_q <= 1'b0;
      end else begin
         on_prev_q  <= on_sync_q;
         off_prev_q <= off_sync_q;
      end
   end

   assign on_rise  = on_sync_q & ~on_prev_q;
   assign off_rise = off_sync_q & ~off_prev_q;

   // group membership: relays whose function code matches relay 1
   always_comb begin
      for (int i = 0; i < NUM_RELAYS; i++) begin
         member[i] = (rif.func[i*FUNC_W +: FUNC_W] == rif.func[FUNC_W-1:0]);
      end
   end

   assign mode           = decode_mode(rif.func[FUNC_W-1:0]);
   assign relay_logic_ok = (rif.logic_set == LOGIC_RELAY);
   assign rate_en        = rif.rate_pumping_select[RSEL_EN_BIT];

   // rate sign follows the pumping direction; short means limit not yet met
   always_comb begin
      if (rif.rate_pumping_select[RSEL_FILL_BIT]) begin
         rate_eff   = 17'(level_rate);
         rate_short = rate_eff < $signed({1'b0, rif.filling_rate_limit});
      end else begin
         rate_eff   = -17'(level_rate);
         rate_short = rate_eff < $signed({1'b0, rif.emptying_rate_limit});
      end
   end

   assign settle_done = (settle_cnt_q == 32'(RATE_SETTLE - 1));

   // settle timer: rate is judged only after each start has had time to act
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_cnt_q <= 32'h00000000;
      end else if (!rate_en || stage_q == 2'h0 || stage_q == 2'(NUM_RELAYS)
                   || stage_d != stage_q || settle_done) begin
         settle_cnt_q <= 32'h00000000;
      end else begin
         settle_cnt_q <= settle_cnt_q + 32'h00000001;
      end
   end

   // setpoint stage: highest ON reached this cycle, or stepped by rate when rate_en; OFF 0 ends the cycle
   always_comb begin
      stage_d = stage_q;
      if (off_rise) begin
         stage_d = 2'h0;
      end else if (rate_en) begin
         if (stage_q == 2'h0 && on_rise != 3'h0) begin
            stage_d = 2'h1;
         end else if (settle_done && rate_short && stage_q != 2'(NUM_RELAYS)) begin
            stage_d = 2'(stage_q + 2'h1);
         end
      end else begin
         for (int k = 0; k < NUM_RELAYS; k++) begin
            if (on_rise[k] && stage_q < 2'(k + 1)) stage_d = 2'(k + 1);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage_q <= 2'h0;
      end else begin
         stage_q <= stage_d;
      end
   end

   // lead rotates once per completed level cycle in alternate duty
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lead_q <= 2'h0;
      end else if (off_rise && stage_q != 2'h0 && mode == MODE_ALT_ASSIST) begin
         lead_q <= next_lead(lead_q);
      end
   end

   relay_mapper relay_mapper_inst (
      .mode   (mode),
      .stage  (stage_q),
      .lead   (lead_q),
      .member (member),
      .relays (relay_d)
   );

   // contacts are registered so a mode change never glitches a pump
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         relay_q <= 3'h0;
      end else if (relay_logic_ok) begin
         relay_q <= relay_d;
      end else begin
         relay_q <= 3'h0;
      end
   end

   // status read back by software
   assign rif.status = {22'h0, stage_q, 2'h0, lead_q, 1'b0, relay_q};

   // checks
   property p_logic_gate;
      @(posedge hclk) disable iff (!hresetn)
      !relay_logic_ok |=> relay_q == 3'h0;
   endproperty
   a_logic_gate: assert property (p_logic_gate)
      else $error("relays closed while relay logic not set");

   property p_group;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (relay_q & ~$past(member)) == 3'h0;
   endproperty
   a_group: assert property (p_group)
      else $error("relay outside the group closed");

   property p_fix_assist;
      @(posedge hclk) disable iff (!hresetn)
      mode == MODE_FIX_ASSIST && relay_logic_ok && member == 3'h7 && stage_q == 2'h2
      |=> relay_q == 3'h3;
   endproperty
   a_fix_assist: assert property (p_fix_assist)
      else $error("fixed assist stage two not relays one and two");

   property p_fix_backup;
      @(posedge hclk) disable iff (!hresetn)
      mode == MODE_FIX_BACKUP && relay_logic_ok && member == 3'h7 && stage_q == 2'h3
      |=> relay_q == 3'h4;
   endproperty
   a_fix_backup: assert property (p_fix_backup)
      else $error("fixed backup stage three not relay three alone");

   property p_backup_one;
      @(posedge hclk) disable iff (!hresetn)
      mode == MODE_FIX_BACKUP |=> $onehot0(relay_q);
   endproperty
   a_backup_one: assert property (p_backup_one)
      else $error("more than one relay closed in fixed backup");

   property p_alt_order;
      @(posedge hclk) disable iff (!hresetn)
      mode == MODE_ALT_ASSIST && relay_logic_ok && member == 3'h7 && lead_q == 2'h1
      && stage_q == 2'h2 |=> relay_q == 3'h6;
   endproperty
   a_alt_order: assert property (p_alt_order)
      else $error("alternate cycle two order wrong");

   property p_rotate;
      @(posedge hclk) disable iff (!hresetn)
      off_rise && stage_q != 2'h0 && mode == MODE_ALT_ASSIST
      |=> lead_q == next_lead($past(lead_q));
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("lead did not advance at end of cycle");

   property p_off_opens;
      @(posedge hclk) disable iff (!hresetn)
      off_rise |=> stage_q == 2'h0 ##1 relay_q == 3'h0;
   endproperty
   a_off_opens: assert property (p_off_opens)
      else $error("relays not open after off setpoint");

   property p_fixed_start;
      @(posedge hclk) disable iff (!hresetn)
      mode == MODE_FIX_ASSIST && relay_logic_ok && member == 3'h7 && !rate_en
      && stage_q == 2'h0 && on_rise == 3'h1 && !off_rise
      |=> ##1 relay_q == 3'h1;
   endproperty
   a_fixed_start: assert property (p_fixed_start)
      else $error("fixed assist did not start relay one");

   property p_rate_step;
      @(posedge hclk) disable iff (!hresetn)
      rate_en && !off_rise && settle_done && rate_short && stage_q == 2'h1
      |=> stage_q == 2'h2;
   endproperty
   a_rate_step: assert property (p_rate_step)
      else $error("pump by rate did not add a pump");

   property p_rate_hold;
      @(posedge hclk) disable iff (!hresetn)
      rate_en && !off_rise && !settle_done && stage_q != 2'h0 |=> stage_q == $past(stage_q);
   endproperty
   a_rate_hold: assert property (p_rate_hold)
      else $error("pump by rate stepped before settle time");

   property p_alt_third;
      @(posedge hclk) disable iff (!hresetn)
      mode == MODE_ALT_ASSIST && relay_logic_ok && member == 3'h7 && lead_q == 2'h2
      && stage_q == 2'h1 |=> relay_q == 3'h4;
   endproperty
   a_alt_third: assert property (p_alt_third)
      else $error("alternate cycle three lead not relay three");

   property p_stage_hold;
      @(posedge hclk) disable iff (!hresetn)
      !rate_en && !off_rise && on_rise == 3'h0 |=> stage_q == $past(stage_q);
   endproperty
   a_stage_hold: assert property (p_stage_hold)
      else $error("stage moved with no setpoint edge");

   property p_lead_hold;
      @(posedge hclk) disable iff (!hresetn)
      !(off_rise && stage_q != 2'h0 && mode == MODE_ALT_ASSIST) |=> lead_q == $past(lead_q);
   endproperty
   a_lead_hold: assert property (p_lead_hold)
      else $error("lead moved outside the end of an alternate cycle");

   // no disable here: the first edge after release is the point of interest
   property p_reset_state;
      @(posedge hclk)
      $rose(hresetn) |-> relay_q == 3'h0 && lead_q == 2'h0 && stage_q == 2'h0;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("relays, lead or stage not at reset state after reset");

   c_fix_all: cover property (@(posedge hclk) disable iff (!hresetn)
      mode == MODE_FIX_ASSIST && relay_q == 3'h7);
   c_backup_three: cover property (@(posedge hclk) disable iff (!hresetn)
      mode == MODE_FIX_BACKUP && relay_q == 3'h4);
   c_alt_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
      mode == MODE_ALT_ASSIST && lead_q == 2'h2 ##[1:1000] lead_q == 2'h0);
   c_rate_add: cover property (@(posedge hclk) disable iff (!hresetn)
      rate_en && stage_q == 2'h1 ##1 stage_q == 2'h2);
endmodule
`default_nettype wire

// ===== sim/pump_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
module pump_motor_model (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic [2:0]    relay_q,
   output logic signed [15:0] level_rate
);
   localparam logic signed [15:0] PUMP_DRAW = 16'sh0028;
   logic [1:0] running;

   // each closed contact runs one pump
   assign running = 2'(relay_q[0]) + 2'(relay_q[1]) + 2'(relay_q[2]);

   // one cycle lag, the level only drops once the motors are turning
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level_rate <= 16'sh0000;
      end else begin
         level_rate <= -($signed({14'h0, running}) * PUMP_DRAW);
      end
   end
endmodule
`default_nettype wire

// ===== sim/test_pump_relay_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_pump_relay_sequencer;
   import pump_pkg::*;
   logic               hclk;
   logic               hresetn;
   logic               hsel;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic [31:0]        hrdata;
   logic               hreadyout;
   logic               hresp;
   logic [2:0]         on_level;
   logic               off_level;
   logic signed [15:0] level_rate;
   logic [2:0]         relay_q;
   int                 n_mismatch;
   int                 cmp_count;
   logic [8:0]         alt_exp [3];

   pump_relay_sequencer #(.RATE_SETTLE(8)) pump_relay_sequencer_inst (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hreadyout),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .on_level  (on_level),
      .off_level (off_level),
      .level_rate(level_rate),
      .relay_q   (relay_q)
   );

   pump_motor_model pump_motor_model_inst (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .relay_q   (relay_q),
      .level_rate(level_rate)
   );

   // free running bus clock
   always #10 hclk = ~hclk;

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // address phase held until hready is seen high
   task automatic bus_addr(input logic [7:0] a, input logic wr);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
   endtask

   // the idle cycle after a write keeps a following read from seeing old data
   task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
      bus_addr(a, 1'b1);
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
   endtask

   task automatic chk_word(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] got;
      bus_addr(a, 1'b0);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      got = hrdata;
      cmp_count++;
      if (got !== exp || hresp !== 1'b0) begin
         n_mismatch++;
         $display("MISMATCH t=%0t addr %h read %h resp %b exp %h", $time, a, got, hresp, exp);
      end
   endtask

   task automatic chk_relay(input logic [2:0] exp);
      cmp_count++;
      if (relay_q !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t relays %b expected %b", $time, relay_q, exp);
      end
   endtask

   // move the level, give the synchroniser and stage logic time, then look
   task automatic level(input logic [2:0] on, input logic off, input logic [2:0] exp);
      on_level  <= on;
      off_level <= off;
      repeat (6) @(posedge hclk);
      chk_relay(exp);
   endtask

   // one full level cycle: ON 1, ON 2, ON 3, then OFF 0
   task automatic level_cycle(input logic [8:0] exp);
      level(3'b001, 1'b0, exp[2:0]);
      level(3'b011, 1'b0, exp[5:3]);
      level(3'b111, 1'b0, exp[8:6]);
      level(3'b000, 1'b1, 3'b000);
      level(3'b000, 1'b0, 3'b000);
   endtask

   task automatic end_test(input string name);
      $display("test %s finished, mismatches so far %0d", name, n_mismatch);
   endtask

   // watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #(20 * 50000);
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      results();
   end

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      on_level = 3'b000;
      off_level = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      alt_exp[0] = {3'b111, 3'b011, 3'b001};
      alt_exp[1] = {3'b111, 3'b110, 3'b010};
      alt_exp[2] = {3'b111, 3'b101, 3'b100};
      repeat (20) @(posedge hclk);
      chk_relay(3'b000);
      hresetn <= 1'b1;
      @(posedge hclk);
      // reset values of every register plus one unmapped word
      for (int i = 0; i < 7; i++) begin
         chk_word(8'(4 * i), 32'h00000000);
      end
      end_test("reset");

      ahb_write(ADDR_LOGIC, 32'hffffff02);
      chk_word(ADDR_LOGIC, 32'h00000002);
      ahb_write(8'h18, 32'hffffffff);
      chk_word(8'h18, 32'h00000000);
      ahb_write(ADDR_STATUS, 32'hffffffff);
      chk_word(ADDR_STATUS, 32'h00000000);
      ahb_write(ADDR_LOGIC, 32'h00000000);
      ahb_write(ADDR_FUNC, 32'hff323232);
      chk_word(ADDR_FUNC, 32'h00323232);
      end_test("registers");

      // relay logic not set: levels must not touch the contacts
      level(3'b001, 1'b0, 3'b000);
      level(3'b111, 1'b0, 3'b000);
      level(3'b000, 1'b1, 3'b000);
      level(3'b000, 1'b0, 3'b000);
      ahb_write(ADDR_LOGIC, 32'h00000002);
      end_test("logic_gate");

      level_cycle({3'b111, 3'b011, 3'b001});
      level_cycle({3'b111, 3'b011, 3'b001});
      chk_word(ADDR_STATUS, 32'h00000000);
      end_test("fixed_assist");

      ahb_write(ADDR_FUNC, 32'h00333333);
      level_cycle({3'b100, 3'b010, 3'b001});
      end_test("fixed_backup");

      // relay 3 carries another code and is outside the group
      ahb_write(ADDR_FUNC, 32'h00003232);
      level_cycle({3'b011, 3'b011, 3'b001});
      end_test("group");

      ahb_write(ADDR_FUNC, 32'h00343434);
      for (int k = 0; k < 4; k++) begin
         level_cycle(alt_exp[k % 3]);
         chk_word(ADDR_STATUS, 32'((k + 1) % 3) << STAT_LEAD_LSB);
      end
      end_test("alternate");

      // two pumps give 80 against a limit of 70, so the third never starts
      ahb_write(ADDR_FUNC, 32'h00323232);
      ahb_write(ADDR_EMPTY, 32'h00000046);
      ahb_write(ADDR_RATE_SEL, 32'h00000001);
      level(3'b001, 1'b0, 3'b001);
      repeat (40) @(posedge hclk);
      chk_relay(3'b011);
      repeat (40) @(posedge hclk);
      chk_relay(3'b011);
      chk_word(ADDR_STATUS, 32'h3 | (32'h2 << STAT_STAGE_LSB) | (32'h1 << STAT_LEAD_LSB));
      // filling direction: the pumps only drain, so the limit is never met
      ahb_write(ADDR_FILL, 32'h00000010);
      ahb_write(ADDR_RATE_SEL, 32'h00000003);
      repeat (40) @(posedge hclk);
      chk_relay(3'b111);
      end_test("pump_by_rate");

      // reset in mid-run with pumps running
      hresetn <= 1'b0;
      @(posedge hclk);
      chk_relay(3'b000);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_word(ADDR_STATUS, 32'h00000000);
      end_test("second_reset");
      results();
   end
endmodule
`default_nettype wire
